// File: verilog/eram_pkg.sv
// Constants and mode codes for the embedded RAM block with port clocking.
// Assumes one system clock; port "clocks" arrive as one-cycle ticks on it.
//
// Contract
// - Input/output clocking for true and simple dual-port
// - Input clock captures data, write enable, address
// - Output clock alone updates read data register
// - Separate enables and clears, input versus output
// - True dual-port: every register clears, read enable too
// - Simple dual-port: read enable ignores clear
// - Read/write clocking: write side, read side clocks
// - Write data, address, enable on write clock
// - Read address, enable, output on read clock
// - Each side own enable and own clear
// - Single-port: one address, one clock; port B still reads on its own address and clock
// - Two single-port RAMs, each within 2K bits
// - Independent clocking: each port one clock for all
package eram_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 16;
  localparam int SP_LIMIT_BITS = 2048;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RDEN_RST = 1'b0;

  // ----------------------------------------------------------------
  // Clocking modes, Gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ERAM_TDP_IO  = 3'h0,
    ERAM_SDP_IO  = 3'h1,
    ERAM_SDP_RW  = 3'h3,
    ERAM_SP      = 3'h2,
    ERAM_SP_DUAL = 3'h6,
    ERAM_TDP_IND = 3'h7
  } eram_mode_t;

endpackage

// File: verilog/eram_port.sv
// One RAM port: input register set and read data output register.
// Assumes ticks, enables and clears are synchronous to ref_clk.
`timescale 1ns/1ps

module eram_port #(
  parameter int AW = eram_pkg::ADDR_W,
  parameter int DW = eram_pkg::DATA_W
) (
  // System
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // Input side
  input  wire logic          in_tick,
  input  wire logic          in_ena,
  input  wire logic          in_clr,
  // Output side
  input  wire logic          out_tick,
  input  wire logic          out_ena,
  input  wire logic          out_clr,
  input  wire logic          rden_clr_ok,
  // User request
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] din,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  // Memory side
  input  wire logic [DW-1:0] mem_q,
  output logic      [AW-1:0] addr_q,
  output logic               wr_fire,
  output logic      [DW-1:0] dout
);

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          rden;
    logic [DW-1:0] dout;
  } eram_port_st_t;

  eram_port_st_t st;
  eram_port_st_t next_st;
  logic          rden_eff;

  // ----------------------------------------------------------------
  // Clear masks outputs at once, not at the next tick
  // ----------------------------------------------------------------
  assign addr_q   = in_clr ? '0 : st.addr;
  assign dout     = out_clr ? '0 : st.dout;
  assign rden_eff = (in_clr && rden_clr_ok) ? 1'b0 : st.rden;
  // Memory writes on the input tick itself
  assign wr_fire  = in_tick && in_ena && wr_en && !in_clr;

  // Next state: input set on input tick, output on output tick
  always_comb begin
    next_st = st;
    if (in_tick && in_ena) begin
      next_st.addr = addr;
      next_st.rden = rd_en;
    end
    if (out_tick && out_ena && rden_eff) begin
      next_st.dout = mem_q;
    end
    // Clears beat any capture in the same cycle, save the read enable capture when rden_clr_ok is low
    if (in_clr) begin
      next_st.addr = '0;
      if (rden_clr_ok) begin
        next_st.rden = 1'b0;
      end
    end
    if (out_clr) begin
      next_st.dout = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st      <= '0;
      st.rden <= eram_pkg::RDEN_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_in_capture;
    @(posedge ref_clk) disable iff (!reset_n)
    (in_tick && in_ena && !in_clr) |=> (in_clr || addr_q == $past(addr));
  endproperty
  a_in_capture: assert property (p_in_capture)
    else $error("address not captured on input tick");

  property p_in_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    (!(in_tick && in_ena) && !in_clr ##1 !in_clr) |-> $stable(addr_q);
  endproperty
  a_in_hold: assert property (p_in_hold)
    else $error("address changed without enabled input tick");

  property p_out_load;
    @(posedge ref_clk) disable iff (!reset_n)
    (out_tick && out_ena && rden_eff && !out_clr)
      |=> (out_clr || dout == $past(mem_q));
  endproperty
  a_out_load: assert property (p_out_load)
    else $error("read data not loaded on output tick");

  property p_out_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    (!(out_tick && out_ena) && !out_clr ##1 !out_clr) |-> $stable(dout);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("read data changed without output tick");

  property p_clr_zero;
    @(posedge ref_clk) disable iff (!reset_n)
    (out_clr |-> dout == '0) and (in_clr |-> addr_q == '0 && !wr_fire);
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear did not force zero");

  property p_rden_keep;
    @(posedge ref_clk) disable iff (!reset_n)
    (in_clr && !rden_clr_ok && !(in_tick && in_ena))
      |=> st.rden == $past(st.rden);
  endproperty
  a_rden_keep: assert property (p_rden_keep)
    else $error("read enable register disturbed by clear");

  c_out_load: cover property (@(posedge ref_clk) disable iff (!reset_n)
    out_tick && out_ena && rden_eff && !out_clr);
  c_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
    in_clr && out_clr);

endmodule

// File: verilog/eram_top.sv
// Embedded RAM block with selectable port clocking modes.
// Assumes port clocks arrive as one-cycle ticks synchronous to ref_clk
// and that cfg_mode is held steady while the block is in use.
`timescale 1ns/1ps

module eram_top #(
  parameter int AW = eram_pkg::ADDR_W,
  parameter int DW = eram_pkg::DATA_W
) (
  // System
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // Configuration
  input  wire logic [2:0]    cfg_mode,
  // Port A controls
  input  wire logic          a_in_clk,
  input  wire logic          a_in_ena,
  input  wire logic          a_in_clr,
  input  wire logic          a_out_clk,
  input  wire logic          a_out_ena,
  input  wire logic          a_out_clr,
  // Port A data
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_din,
  input  wire logic          a_wr_en,
  input  wire logic          a_rd_en,
  output logic      [DW-1:0] a_dout,
  // Port B controls
  input  wire logic          b_in_clk,
  input  wire logic          b_in_ena,
  input  wire logic          b_in_clr,
  input  wire logic          b_out_clk,
  input  wire logic          b_out_ena,
  input  wire logic          b_out_clr,
  // Port B data
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_din,
  input  wire logic          b_wr_en,
  input  wire logic          b_rd_en,
  output logic      [DW-1:0] b_dout
);

  localparam int DEPTH = 1 << AW;
  // Split mode gives each port half the array
  localparam int HALF_BITS = (DEPTH / 2) * DW;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
  } eram_st_t;

  eram_st_t           st;
  eram_st_t           next_st;
  eram_pkg::eram_mode_t mode;

  // Per-port views, index 0 is A, index 1 is B
  logic [1:0]         in_tick, in_ena, in_clr;
  logic [1:0]         out_tick, out_ena, out_clr;
  logic [1:0]         wr_en, rd_en, wr_fire;
  logic [1:0]         raw_otick, raw_oena, raw_oclr;
  logic [1:0]         raw_wr, raw_rd;
  logic [1:0][AW-1:0] raw_addr, map_addr, addr_q;
  logic [1:0][DW-1:0] din, mem_q, dout;
  logic               rden_clr_ok;

  assign mode = eram_pkg::eram_mode_t'(cfg_mode);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic is_sdp(eram_pkg::eram_mode_t m);
    return (m == eram_pkg::ERAM_SDP_IO) || (m == eram_pkg::ERAM_SDP_RW);
  endfunction

  // True when a port runs all its registers off its input clock
  function automatic logic one_clock(eram_pkg::eram_mode_t m, int p);
    return (m == eram_pkg::ERAM_TDP_IND) || (m == eram_pkg::ERAM_SP) ||
           (m == eram_pkg::ERAM_SP_DUAL) ||
           (m == eram_pkg::ERAM_SDP_RW && p == 1);
  endfunction

  // Gather raw pins into per-port vectors
  assign in_tick   = {b_in_clk, a_in_clk};
  assign in_ena    = {b_in_ena, a_in_ena};
  assign in_clr    = {b_in_clr, a_in_clr};
  assign raw_otick = {b_out_clk, a_out_clk};
  assign raw_oena  = {b_out_ena, a_out_ena};
  assign raw_oclr  = {b_out_clr, a_out_clr};
  assign raw_wr    = {b_wr_en, a_wr_en};
  assign raw_rd    = {b_rd_en, a_rd_en};
  assign raw_addr  = {b_addr, a_addr};
  assign din       = {b_din, a_din};
  assign a_dout    = dout[0];
  assign b_dout    = dout[1];

  // Only simple dual-port keeps read enable through a clear
  assign rden_clr_ok = !is_sdp(mode);

  // ----------------------------------------------------------------
  // Port clock, enable and clear routing per mode
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    always_comb begin
      if (one_clock(mode, p)) begin
        out_tick[p] = in_tick[p];
        out_ena[p]  = in_ena[p];
        out_clr[p]  = in_clr[p];
      end else begin
        out_tick[p] = raw_otick[p];
        out_ena[p]  = raw_oena[p];
        out_clr[p]  = raw_oclr[p];
      end
      // Read enable matters only in simple dual-port, on both ports
      rd_en[p] = is_sdp(mode) ? raw_rd[p] : 1'b1;
      // Port B is read-only in simple dual-port and in single-port
      if ((is_sdp(mode) || mode == eram_pkg::ERAM_SP) && p == 1) begin
        wr_en[p] = 1'b0;
      end else begin
        wr_en[p] = raw_wr[p];
      end
      // Split mode pins each port to its own half
      map_addr[p] = raw_addr[p];
      if (mode == eram_pkg::ERAM_SP_DUAL) begin
        map_addr[p][AW-1] = (p == 1);
      end
    end

    assign mem_q[p] = st.mem[addr_q[p]];

    eram_port #(
      .AW (AW),
      .DW (DW)
    ) eram_port_i (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .in_tick     (in_tick[p]),
      .in_ena      (in_ena[p]),
      .in_clr      (in_clr[p]),
      .out_tick    (out_tick[p]),
      .out_ena     (out_ena[p]),
      .out_clr     (out_clr[p]),
      .rden_clr_ok (rden_clr_ok),
      .addr        (map_addr[p]),
      .din         (din[p]),
      .wr_en       (wr_en[p]),
      .rd_en       (rd_en[p]),
      .mem_q       (mem_q[p]),
      .addr_q      (addr_q[p]),
      .wr_fire     (wr_fire[p]),
      .dout        (dout[p])
    );
  end

  // ----------------------------------------------------------------
  // Array write; B first so A wins a same-address collision
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr_fire[1]) begin
      next_st.mem[map_addr[1]] = din[1];
    end
    if (wr_fire[0]) begin
      next_st.mem[map_addr[0]] = din[0];
    end
  end

  // Contents ignore port clears, only system reset empties them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mem_write;
    @(posedge ref_clk) disable iff (!reset_n)
    wr_fire[0] |=> st.mem[$past(map_addr[0])] == $past(din[0]);
  endproperty
  a_mem_write: assert property (p_mem_write)
    else $error("port A write did not reach the array");

  property p_sdp_b_ro;
    @(posedge ref_clk) disable iff (!reset_n)
    is_sdp(mode) |-> !wr_fire[1];
  endproperty
  a_sdp_b_ro: assert property (p_sdp_b_ro)
    else $error("read side wrote in simple dual-port");

  property p_split_half;
    @(posedge ref_clk) disable iff (!reset_n)
    (mode == eram_pkg::ERAM_SP_DUAL) |->
      (!wr_fire[0] || !map_addr[0][AW-1]) &&
      (!wr_fire[1] || map_addr[1][AW-1]) &&
      HALF_BITS <= eram_pkg::SP_LIMIT_BITS;
  endproperty
  a_split_half: assert property (p_split_half)
    else $error("split single-port left its half");

  property p_rw_read_clk;
    @(posedge ref_clk) disable iff (!reset_n)
    (mode == eram_pkg::ERAM_SDP_RW) |->
      out_tick[1] == in_tick[1] && out_clr[1] == in_clr[1];
  endproperty
  a_rw_read_clk: assert property (p_rw_read_clk)
    else $error("read side not on one read clock");

  property p_io_sep;
    @(posedge ref_clk) disable iff (!reset_n)
    (mode == eram_pkg::ERAM_TDP_IO) |->
      out_tick[0] == a_out_clk && out_clr[1] == b_out_clr;
  endproperty
  a_io_sep: assert property (p_io_sep)
    else $error("output side not on its own clock");

  c_collide: cover property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire[0] && wr_fire[1] && map_addr[0] == map_addr[1]);
  c_split: cover property (@(posedge ref_clk) disable iff (!reset_n)
    mode == eram_pkg::ERAM_SP_DUAL && wr_fire[0] && wr_fire[1]);

endmodule

// File: tb/eram_fabric.sv
// Fabric-side user logic for one RAM port: ticks, enables, clears.
// Assumes port clocks are one-cycle ticks sampled on ref_clk.
`timescale 1ns/1ps

module eram_fabric #(
  parameter int GAP = 0
) (
  // System
  input  wire logic                        ref_clk,
  // Controls
  output logic                             in_clk,
  output logic                             in_ena,
  output logic                             in_clr,
  output logic                             out_clk,
  output logic                             out_ena,
  output logic                             out_clr,
  // Requests
  output logic [eram_pkg::ADDR_W-1:0]      addr,
  output logic [eram_pkg::DATA_W-1:0]      din,
  output logic                             wr_en,
  output logic                             rd_en,
  input  wire logic [eram_pkg::DATA_W-1:0] dout
);
  // Quiet port at time zero
  initial begin
    {in_clk, in_clr, out_clk, out_ena, out_clr, wr_en, rd_en} = '0;
    in_ena = 1'b1;
    addr   = '0;
    din    = '0;
  end

  // Released lines toggle so stale data never looks valid
  task automatic idle();
    in_clk  <= 1'b0;
    out_clk <= 1'b0;
    wr_en   <= 1'b0;
    addr    <= ~addr;
    din     <= ~din;
  endtask

  // One write tick; en low shows a gated tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic en);
    @(posedge ref_clk);
    addr   <= a;
    din    <= d;
    wr_en  <= 1'b1;
    in_ena <= en;
    in_clk <= 1'b1;
    @(posedge ref_clk);
    idle();
    in_ena <= 1'b1;
  endtask

  // Output tick, with or without an input tick beside it
  task automatic tick(input logic with_in, output logic [15:0] q);
    @(posedge ref_clk);
    in_clk  <= with_in;
    out_clk <= 1'b1;
    out_ena <= 1'b1;
    @(posedge ref_clk);
    idle();
    #1;
    q = dout;
  endtask

  // Address tick, GAP+1 idle cycles, then output tick
  task automatic rd(input logic [7:0] a, input logic re,
                    output logic [15:0] early, output logic [15:0] q);
    @(posedge ref_clk);
    addr   <= a;
    rd_en  <= re;
    in_clk <= 1'b1;
    @(posedge ref_clk);
    in_clk <= 1'b0;
    repeat (GAP) @(posedge ref_clk);
    #1;
    early = dout;
    tick(1'b1, q);
  endtask

  // One-cycle clear; q is sampled while the clear is in force
  task automatic clr(input logic side_in, output logic [15:0] q);
    @(posedge ref_clk);
    in_clr  <= side_in;
    out_clr <= !side_in;
    #1;
    q = dout;
    @(posedge ref_clk);
    in_clr  <= 1'b0;
    out_clr <= 1'b0;
  endtask
endmodule

// File: tb/embedded_ram_clock_modes_bench.sv
// Self-checking bench for eram_top: every clocking mode in turn.
// Assumes eram_fabric drives each port; reset between modes.
`timescale 1ns/1ps

module embedded_ram_clock_modes_bench;
  logic        ref_clk, reset_n;
  logic [2:0]  cfg_mode;
  logic        a_in_clk, a_in_ena, a_in_clr, a_out_clk, a_out_ena;
  logic        a_out_clr, a_wr_en, a_rd_en;
  logic        b_in_clk, b_in_ena, b_in_clr, b_out_clk, b_out_ena;
  logic        b_out_clr, b_wr_en, b_rd_en;
  logic [7:0]  a_addr, b_addr;
  logic [15:0] a_din, a_dout, b_din, b_dout, e, q;
  int          mismatches = 0;
  int          num_checks = 0;

  // ------------------------------------------------------------
  // Design and two fabric ports, B answers slowly
  // ------------------------------------------------------------
  eram_top eram_top_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .cfg_mode(cfg_mode),
    .a_in_clk(a_in_clk), .a_in_ena(a_in_ena), .a_in_clr(a_in_clr),
    .a_out_clk(a_out_clk), .a_out_ena(a_out_ena),
    .a_out_clr(a_out_clr), .a_addr(a_addr), .a_din(a_din),
    .a_wr_en(a_wr_en), .a_rd_en(a_rd_en), .a_dout(a_dout),
    .b_in_clk(b_in_clk), .b_in_ena(b_in_ena), .b_in_clr(b_in_clr),
    .b_out_clk(b_out_clk), .b_out_ena(b_out_ena),
    .b_out_clr(b_out_clr), .b_addr(b_addr), .b_din(b_din),
    .b_wr_en(b_wr_en), .b_rd_en(b_rd_en), .b_dout(b_dout));

  eram_fabric #(.GAP(0)) pa (
    .ref_clk(ref_clk), .in_clk(a_in_clk), .in_ena(a_in_ena),
    .in_clr(a_in_clr), .out_clk(a_out_clk), .out_ena(a_out_ena),
    .out_clr(a_out_clr), .addr(a_addr), .din(a_din),
    .wr_en(a_wr_en), .rd_en(a_rd_en), .dout(a_dout));

  eram_fabric #(.GAP(3)) pb (
    .ref_clk(ref_clk), .in_clk(b_in_clk), .in_ena(b_in_ena),
    .in_clr(b_in_clr), .out_clk(b_out_clk), .out_ena(b_out_ena),
    .out_clr(b_out_clr), .addr(b_addr), .din(b_din),
    .wr_en(b_wr_en), .rd_en(b_rd_en), .dout(b_dout));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Mode only changes under reset, which also empties the array
  task automatic set_mode(input logic [2:0] m);
    @(posedge ref_clk);
    reset_n  <= 1'b0;
    cfg_mode <= m;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  // Watchdog well beyond the roughly 150 cycles the tests take
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    results();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    reset_n  = 1'b0;
    cfg_mode = 3'h0;
    set_mode(eram_pkg::ERAM_TDP_IO);
    pa.wr(8'h10, 16'h1111, 1'b1);
    pb.wr(8'h20, 16'h2222, 1'b1);
    pa.wr(8'h10, 16'hdead, 1'b0);
    pa.rd(8'h20, 1'b1, e, q);
    chk("a_dout", 16'h2222, q);
    pb.rd(8'h10, 1'b1, e, q);
    chk("b_dout", 16'h1111, q);
    pb.rd(8'h20, 1'b1, e, q);
    chk("b_dout early", 16'h1111, e);
    chk("b_dout", 16'h2222, q);
    pb.clr(1'b0, q);
    chk("b_dout cleared", 16'h0000, q);
    pb.rd(8'h20, 1'b1, e, q);
    chk("b_dout kept", 16'h2222, q);
    pa.clr(1'b1, q);
    chk("a_dout in clear", 16'h2222, q);
    pa.tick(1'b0, q);
    chk("a_dout rden cleared", 16'h2222, q);
    $display("Test tdp_io done");

    set_mode(eram_pkg::ERAM_SDP_IO);
    pa.wr(8'h00, 16'h0f0f, 1'b1);
    pa.wr(8'h30, 16'h3333, 1'b1);
    pb.wr(8'h30, 16'hbad0, 1'b1);
    pb.rd(8'h30, 1'b1, e, q);
    chk("b_dout", 16'h3333, q);
    pb.rd(8'h00, 1'b0, e, q);
    chk("b_dout no rden", 16'h3333, q);
    pb.rd(8'h30, 1'b1, e, q);
    pb.clr(1'b1, q);
    chk("b_dout in clear", 16'h3333, q);
    pb.tick(1'b0, q);
    chk("b_dout rden kept", 16'h0f0f, q);
    $display("Test sdp_io done");

    set_mode(eram_pkg::ERAM_SDP_RW);
    pa.wr(8'h40, 16'h4444, 1'b1);
    pa.wr(8'h41, 16'h4545, 1'b0);
    pb.rd(8'h40, 1'b1, e, q);
    chk("b_dout", 16'h4444, q);
    pb.rd(8'h41, 1'b1, e, q);
    chk("b_dout gated", 16'h0000, q);
    $display("Test sdp_rw done");

    set_mode(eram_pkg::ERAM_SP);
    pa.wr(8'h05, 16'h5555, 1'b1);
    pb.wr(8'h06, 16'h6666, 1'b1);
    pa.rd(8'h05, 1'b1, e, q);
    chk("a_dout", 16'h5555, q);
    pa.rd(8'h06, 1'b1, e, q);
    chk("a_dout", 16'h0000, q);
    $display("Test sp done");

    set_mode(eram_pkg::ERAM_SP_DUAL);
    pa.wr(8'h05, 16'ha5a5, 1'b1);
    pb.wr(8'h05, 16'hb5b5, 1'b1);
    pa.rd(8'h85, 1'b1, e, q);
    chk("a_dout", 16'ha5a5, q);
    pb.rd(8'h05, 1'b1, e, q);
    chk("b_dout", 16'hb5b5, q);
    $display("Test sp_dual done");

    set_mode(eram_pkg::ERAM_TDP_IND);
    pa.wr(8'h77, 16'h7777, 1'b1);
    pb.wr(8'h78, 16'h7878, 1'b0);
    pb.rd(8'h77, 1'b1, e, q);
    chk("b_dout", 16'h7777, q);
    pa.rd(8'h78, 1'b1, e, q);
    chk("a_dout", 16'h0000, q);
    $display("Test tdp_ind done");
    results();
  end
endmodule
